/* File: rtl/tae_cfg.svh */
`ifndef TAE_CFG_SVH
`define TAE_CFG_SVH

// ==========================================================================
// register pointers
`define TAE_PTR_CONFIG 8'h01
`define TAE_PTR_UPPER 8'h02
`define TAE_PTR_LOWER 8'h03
`define TAE_PTR_CRIT 8'h04
`define TAE_PTR_TEMP 8'h05

// ==========================================================================
// field positions and masks
`define TAE_CFG_WIDTH 11
`define TAE_CFG_CLEAR_BIT 5
`define TAE_TEMP_VAL_WIDTH 13
`define TAE_THR_WMASK 16'h1FFC

// ==========================================================================
// reset values
`define TAE_CFG_RESET 11'h000
`define TAE_THR_RESET 16'h0000
`define TAE_TEMP_RESET 13'h0000

// ==========================================================================
// hysteresis in temperature lsb (0.0625 C): 0, 1.5, 3, 6 C
`define TAE_HYST_0 14'h0000
`define TAE_HYST_1 14'h0018
`define TAE_HYST_2 14'h0030
`define TAE_HYST_3 14'h0060

// ==========================================================================
// timing
`define TAE_CONV_PERIOD_MS 125
`define TAE_CLK_FREQ_HZ 100000000
`define TAE_CONV_CYCLES ((64'd`TAE_CONV_PERIOD_MS * 64'd`TAE_CLK_FREQ_HZ) / 64'd1000)

`endif

/* File: rtl/tae_pkg.sv */
`default_nettype none
package tae_pkg;

    // configuration register, bit 0 at the bottom
    typedef struct packed {
        logic [1:0] hyst;
        logic shutdown;
        logic crit_lock;
        logic win_lock;
        logic clear;
        logic status;
        logic en;
        logic crit_only;
        logic pol;
        logic int_mode;
    } tae_cfg_t;

    typedef struct packed {
        logic crit;
        logic above;
        logic below;
        logic [12:0] value;
    } tae_temp_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] ptr;
        logic [15:0] wdata;
    } tae_reg_req_t;

endpackage
`default_nettype wire

/* File: rtl/tae_trip_cmp.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// one threshold with hysteresis; flag moves only on eval
module tae_trip_cmp #(
    parameter bit BELOW = 1'b0,
    parameter bit INCL = 1'b0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // compare inputs
    input wire logic eval,
    input wire logic [13:0] temp,
    input wire logic [13:0] thr,
    input wire logic [13:0] hyst,
    // result
    output logic flag
);

    logic flag_q;
    logic flag_d;
    logic signed [14:0] t_w;
    logic signed [14:0] th_w;
    logic signed [14:0] hy_w;
    logic signed [14:0] band_w;
    logic set_w;
    logic rel_w;

    // one extra bit keeps threshold +/- hysteresis from wrapping
    assign t_w = {temp[13], temp};
    assign th_w = {thr[13], thr};
    assign hy_w = {1'b0, hyst};
    assign band_w = BELOW ? (th_w + hy_w) : (th_w - hy_w);
    assign set_w = BELOW ? (t_w < th_w) : (INCL ? (t_w >= th_w) : (t_w > th_w));
    assign rel_w = BELOW ? (t_w >= band_w) : (INCL ? (t_w < band_w) : (t_w <= band_w));
    assign flag_d = eval ? (flag_q ? ~rel_w : set_w) : flag_q;
    assign flag = flag_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            flag_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/tae_event_top.sv */
// What this block does
// - comparator mode: alarm while temperature above upper or below lower threshold.
// - critical-only banding: alarm only at or above critical threshold, window ignored.
// - comparator mode alarm is unaffected by register reads or writes.
// - comparator alarm holds until temperature or new thresholds put it inside window.
// - interrupt mode: alarm on every window crossing, entering or leaving.
// - interrupt mode: writing clear-event bit drops alarm until next trigger.
// - outside critical, latched interrupt alarm clears by clear bit, or by alert response when polarity is active-low.
// - at critical threshold alarm asserts and holds until temperature falls below.
// - during critical condition clear bit and alert response are ignored.
// - cleared interrupt alarm reasserts at critical, drops once below critical.
// - uncleared alarm drops by itself when temperature falls below critical.
// - in critical band output acts as comparator, mode bit ignored.
// - temperature register reports above-critical, above-window, below-window flags.
// - upper threshold at pointer 02h, lower at 03h, both host writable.
// - critical threshold at pointer 04h, applied with configured hysteresis.
// - window flags release only after moving back by hysteresis amount.
// - a written threshold is used only after one full conversion period.
// - conversions run at least eight per second, each updating temperature.
// - configuration selects mode, polarity, banding, enable, status, clear, locks, hysteresis.
// - alarm pin stays released after reset until output enable is set.
// - alarm asserted on entering shutdown stays asserted through shutdown.
`timescale 1ns/100ps
`default_nettype none
`include "tae_cfg.svh"

module tae_event_top #(
    parameter int unsigned CONV_CYCLES = 32'(`TAE_CONV_CYCLES)
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register port behind the serial bus
    input wire tae_pkg::tae_reg_req_t reg_req,
    output logic [15:0] reg_rd_data,
    output logic reg_rd_valid,
    input wire logic alert_resp_won,
    // converter link
    output logic conv_req,
    input wire logic conv_strobe,
    input wire logic [12:0] conv_data,
    // open-drain alarm pin
    output logic event_out,
    output logic event_oe
);

    localparam int CW = $clog2(CONV_CYCLES + 1);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
    localparam logic [CW-1:0] SETTLE_LOAD = CW'(CONV_CYCLES);

    // ======================================================================
    // decode helpers
    function automatic logic [7:0] thr_ptr(input int idx);
        thr_ptr = (idx == 0) ? `TAE_PTR_CRIT : ((idx == 1) ? `TAE_PTR_UPPER : `TAE_PTR_LOWER);
    endfunction

    function automatic logic [13:0] hyst_lsb(input logic [1:0] sel);
        case (sel)
            2'h0: hyst_lsb = `TAE_HYST_0;
            2'h1: hyst_lsb = `TAE_HYST_1;
            2'h2: hyst_lsb = `TAE_HYST_2;
            default: hyst_lsb = `TAE_HYST_3;
        endcase
    endfunction

    // ======================================================================
    // state
    tae_pkg::tae_cfg_t cfg_q;
    tae_pkg::tae_cfg_t cfg_d;
    tae_pkg::tae_cfg_t cfg_w;
    logic [15:0] thr_q [3];
    logic [15:0] act_q [3];
    logic [CW-1:0] settle_q;
    logic [CW-1:0] conv_cnt_q;
    logic conv_req_q;
    logic [12:0] temp_q;
    logic strb_s1_q;
    logic strb_s2_q;
    logic strb_s3_q;
    logic [12:0] data_s1_q;
    logic [12:0] data_s2_q;
    logic eval_q;
    logic [1:0] win_prev_q;
    logic crit_prev_q;
    logic int_q;
    logic int_d;
    logic event_oe_q;
    logic event_out_q;
    logic [15:0] rd_data_q;
    logic rd_valid_q;

    // ======================================================================
    // decode
    logic wr_cfg;
    logic [2:0] wr_thr;
    logic [2:0] trip;
    logic [13:0] thr_s [3];
    logic [13:0] temp_s;
    logic [13:0] hyst_w;
    logic strb_rise;
    logic crit_fall;
    logic win_chg;
    logic clr_req;
    logic clr_ok;
    logic alarm;
    logic drive_low;
    logic thr_any_wr;
    logic conv_tick;
    tae_pkg::tae_temp_t temp_reg;
    tae_pkg::tae_cfg_t cfg_rd;
    logic [15:0] rd_data_d;

    assign wr_cfg = reg_req.wr && (reg_req.ptr == `TAE_PTR_CONFIG);
    assign cfg_w = tae_pkg::tae_cfg_t'(reg_req.wdata[`TAE_CFG_WIDTH-1:0]);
    assign temp_s = {temp_q[12], temp_q};
    assign hyst_w = hyst_lsb(cfg_q.hyst);
    assign thr_any_wr = |wr_thr;
    assign conv_tick = (conv_cnt_q == CONV_LAST);

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_trip
            // threshold writes are refused while their lock is set
            assign wr_thr[gi] = reg_req.wr && (reg_req.ptr == thr_ptr(gi))
                && !((gi == 0) ? cfg_q.crit_lock : cfg_q.win_lock);
            assign thr_s[gi] = {act_q[gi][12], act_q[gi][12:0]};
            tae_trip_cmp #(
                .BELOW(gi == 2),
                .INCL(gi == 0)
            ) u_cmp (
                .ref_clk(ref_clk),
                .rst_b(rst_b),
                .eval(eval_q),
                .temp(temp_s),
                .thr(thr_s[gi]),
                .hyst(hyst_w),
                .flag(trip[gi])
            );
        end
    endgenerate

    // once the output is enabled the mode and banding bits are frozen
    always_comb
    begin
        cfg_d = cfg_q;
        if (wr_cfg)
        begin
            cfg_d = cfg_w;
            cfg_d.status = 1'b0;
            cfg_d.clear = 1'b0;
            cfg_d.win_lock = cfg_q.win_lock | cfg_w.win_lock;
            cfg_d.crit_lock = cfg_q.crit_lock | cfg_w.crit_lock;
            cfg_d.int_mode = cfg_q.en ? cfg_q.int_mode : cfg_w.int_mode;
            cfg_d.crit_only = cfg_q.en ? cfg_q.crit_only : cfg_w.crit_only;
        end
    end

    // ======================================================================
    // converter link
    assign strb_rise = strb_s2_q && !strb_s3_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            strb_s1_q <= 1'b0;
            strb_s2_q <= 1'b0;
            strb_s3_q <= 1'b0;
            data_s1_q <= `TAE_TEMP_RESET;
            data_s2_q <= `TAE_TEMP_RESET;
        end
        else
        begin
            strb_s1_q <= conv_strobe;
            strb_s2_q <= strb_s1_q;
            strb_s3_q <= strb_s2_q;
            data_s1_q <= conv_data;
            data_s2_q <= data_s1_q;
        end
    end

    // conversion requests stop in shutdown, so the alarm freezes there
    always_ff @(posedge ref_clk)
    begin
        conv_cnt_q <= (!rst_b || cfg_q.shutdown || conv_tick) ? '0 : conv_cnt_q + 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            conv_req_q <= 1'b0;
            temp_q <= `TAE_TEMP_RESET;
            eval_q <= 1'b0;
        end
        else
        begin
            conv_req_q <= conv_tick && !cfg_q.shutdown;
            eval_q <= strb_rise;
            // data settles before the strobe rises and holds while it is high
            temp_q <= strb_rise ? data_s2_q : temp_q;
        end
    end

    // ======================================================================
    // registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            cfg_q <= tae_pkg::tae_cfg_t'(`TAE_CFG_RESET);
        end
        else
        begin
            cfg_q <= cfg_d;
        end
    end

    // a rewritten threshold waits out one conversion period before use
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            settle_q <= '0;
        end
        else
        begin
            settle_q <= thr_any_wr ? SETTLE_LOAD : (settle_q - CW'(settle_q != '0));
        end
    end

    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (!rst_b)
            begin
                thr_q[i] <= `TAE_THR_RESET;
                act_q[i] <= `TAE_THR_RESET;
            end
            else
            begin
                thr_q[i] <= wr_thr[i] ? (reg_req.wdata & `TAE_THR_WMASK) : thr_q[i];
                act_q[i] <= (settle_q == '0 && !thr_any_wr) ? thr_q[i] : act_q[i];
            end
        end
    end

    // ======================================================================
    // alarm decision
    assign crit_fall = crit_prev_q && !trip[0];
    assign win_chg = cfg_q.int_mode && ({trip[1], trip[2]} != win_prev_q);
    assign clr_req = (wr_cfg && reg_req.wdata[`TAE_CFG_CLEAR_BIT])
        || (alert_resp_won && cfg_q.int_mode && !cfg_q.pol);
    assign clr_ok = clr_req && !trip[0];
    // a new crossing wins over a clear in the same cycle
    assign int_d = !cfg_q.int_mode ? 1'b0 :
        (win_chg ? 1'b1 : ((clr_ok || crit_fall) ? 1'b0 : int_q));
    assign alarm = trip[0]
        || (!cfg_q.crit_only
            && (cfg_q.int_mode ? int_q : (trip[1] || trip[2])));
    assign drive_low = cfg_q.en && (alarm ^ cfg_q.pol);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            win_prev_q <= 2'h0;
            crit_prev_q <= 1'b0;
            int_q <= 1'b0;
        end
        else
        begin
            win_prev_q <= {trip[1], trip[2]};
            crit_prev_q <= trip[0];
            int_q <= int_d;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            event_oe_q <= 1'b0;
            event_out_q <= 1'b0;
        end
        else
        begin
            event_oe_q <= cfg_q.shutdown ? event_oe_q : drive_low;
        end
    end

    // ======================================================================
    // read back
    assign temp_reg = '{crit: trip[0], above: trip[1], below: trip[2], value: temp_q};
    always_comb
    begin
        cfg_rd = cfg_q;
        cfg_rd.status = alarm;
        cfg_rd.clear = 1'b0;
    end
    assign rd_data_d = (reg_req.ptr == `TAE_PTR_CONFIG) ? {5'h00, cfg_rd} :
        (reg_req.ptr == `TAE_PTR_UPPER) ? thr_q[1] :
        (reg_req.ptr == `TAE_PTR_LOWER) ? thr_q[2] :
        (reg_req.ptr == `TAE_PTR_CRIT) ? thr_q[0] :
        (reg_req.ptr == `TAE_PTR_TEMP) ? temp_reg : 16'h0000;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rd_data_q <= 16'h0000;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= reg_req.rd;
            rd_data_q <= reg_req.rd ? rd_data_d : rd_data_q;
        end
    end

    // ======================================================================
    // outputs
    assign reg_rd_data = rd_data_q;
    assign reg_rd_valid = rd_valid_q;
    assign conv_req = conv_req_q;
    assign event_out = event_out_q;
    assign event_oe = event_oe_q;

endmodule

`default_nettype wire

/* File: dv/tae_event_props.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// port-level checks of the alarm block
module tae_event_props #(
    parameter int unsigned CONV_CYCLES = 200
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // register port
    input wire tae_pkg::tae_reg_req_t reg_req,
    input wire logic [15:0] reg_rd_data,
    input wire logic reg_rd_valid,
    input wire logic alert_resp_won,
    // converter link
    input wire logic conv_req,
    input wire logic conv_strobe,
    input wire logic [12:0] conv_data,
    // alarm pin
    input wire logic event_out,
    input wire logic event_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic strobe_q;
    logic sd_q;
    logic [31:0] gap_q;
    logic [3:0] age_q;
    wire strobe_rise = conv_strobe && !strobe_q;
    // the alarm pin may only move shortly after a conversion, a write or an alert
    wire cause = reg_req.wr || alert_resp_won || strobe_rise;
    wire rd_spare = reg_req.rd && (reg_req.ptr == 8'h00 || reg_req.ptr > 8'h05);
    wire rd_thr = reg_req.rd && reg_req.ptr >= 8'h02 && reg_req.ptr <= 8'h04;
    always_ff @(posedge ref_clk)
    begin
        strobe_q <= conv_strobe;
        // conversions pause in shutdown, so the gap restarts there
        sd_q <= !rst_b ? 1'b0 : ((reg_req.wr && reg_req.ptr == 8'h01) ? reg_req.wdata[8] : sd_q);
        gap_q <= (!rst_b || conv_req || sd_q) ? 32'h0 : gap_q + 32'h1;
        age_q <= (!rst_b || cause) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
    end
    sequence rd_taken;
        reg_req.rd;
    endsequence
    sequence rd_answered;
        reg_rd_valid;
    endsequence
    chk_read_answer: assert property (rd_taken |=> rd_answered)
        else $error("read not answered");
    chk_valid_cause: assert property (!reg_req.rd |=> !reg_rd_valid)
        else $error("valid without read");
    chk_data_hold: assert property ($changed(reg_rd_data) |-> reg_rd_valid)
        else $error("read data moved");
    chk_unmapped_zero: assert property (rd_spare |=> reg_rd_data == 16'h0000)
        else $error("unmapped read not zero");
    chk_cfg_spare_zero: assert property (reg_req.rd && reg_req.ptr == 8'h01
        |=> reg_rd_data[15:11] == 5'h00 && !reg_rd_data[5])
        else $error("config spare bits set");
    chk_thr_mask: assert property (rd_thr |=> (reg_rd_data & 16'hE003) == 16'h0000)
        else $error("threshold spare bits set");
    chk_conv_rate: assert property (gap_q <= CONV_CYCLES + 1)
        else $error("conversion overdue");
    chk_oe_cause: assert property ($changed(event_oe) |-> age_q <= 4'h8)
        else $error("alarm moved without cause");
    chk_reset_idle: assert property ($rose(rst_b)
        |-> !event_oe && !conv_req && !reg_rd_valid && reg_rd_data == 16'h0000)
        else $error("outputs busy after reset");
endmodule

bind tae_event_top tae_event_props #(.CONV_CYCLES(CONV_CYCLES)) i_props (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .alert_resp_won(alert_resp_won), .conv_req(conv_req),
    .conv_strobe(conv_strobe), .conv_data(conv_data), .event_out(event_out),
    .event_oe(event_oe));
`default_nettype wire

/* File: dv/tae_conv_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// converter stand-in: one 103 ns link frame per request, idle between
module tae_conv_model (
    // clock and request
    input wire logic ref_clk,
    input wire logic conv_req,
    input wire logic [12:0] temp_set,
    // converter link
    output logic conv_strobe,
    output logic [12:0] conv_data
);
    initial
    begin
        conv_strobe = 1'b0;
        conv_data = 13'h0AAA;
    end
    always
    begin
        @(posedge ref_clk iff conv_req === 1'b1);
        #13 conv_data = temp_set;
        // strobe lands between clock edges, never on one
        #10 conv_strobe = 1'b1;
        #40 conv_strobe = 1'b0;
        // data is no longer valid: show the inverse, not the old value
        #40 conv_data = ~conv_data;
    end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// bench
module tb;
    typedef struct packed {
        logic [15:0] cfg;
        logic [12:0] temp;
        logic [2:0] flags;
        logic oe;
    } tae_row_t;
    localparam int unsigned CONV = 200;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    tae_pkg::tae_reg_req_t reg_req = '0;
    logic alert_resp_won = 1'b0;
    logic [12:0] temp_set = 13'h0300;
    logic [15:0] reg_rd_data;
    logic reg_rd_valid;
    logic conv_req;
    logic conv_strobe;
    logic [12:0] conv_data;
    logic event_out;
    logic event_oe;
    logic [15:0] cur_cfg;
    int fails = 0;
    int samples_checked = 0;
    // window 0140..0550, critical 05F0; the last six rows add hysteresis
    tae_row_t rows [18] = '{
        {16'h0008, 13'h0300, 3'h0, 1'b0}, {16'h0008, 13'h0551, 3'h2, 1'b1},
        {16'h0008, 13'h0550, 3'h0, 1'b0}, {16'h0008, 13'h013F, 3'h1, 1'b1},
        {16'h0008, 13'h0140, 3'h0, 1'b0}, {16'h0008, 13'h1F40, 3'h1, 1'b1},
        {16'h0008, 13'h05F0, 3'h6, 1'b1}, {16'h0008, 13'h05EF, 3'h2, 1'b1},
        {16'h000C, 13'h0551, 3'h2, 1'b0}, {16'h000C, 13'h05F0, 3'h6, 1'b1},
        {16'h000A, 13'h0300, 3'h0, 1'b1}, {16'h000A, 13'h0551, 3'h2, 1'b0},
        {16'h0208, 13'h0551, 3'h2, 1'b1}, {16'h0208, 13'h0539, 3'h2, 1'b1},
        {16'h0208, 13'h0538, 3'h0, 1'b0}, {16'h0608, 13'h0551, 3'h2, 1'b1},
        {16'h0608, 13'h04F1, 3'h2, 1'b1}, {16'h0608, 13'h04F0, 3'h0, 1'b0}};

    always #5 ref_clk = ~ref_clk;

    tae_event_top #(.CONV_CYCLES(CONV)) i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .alert_resp_won(alert_resp_won), .conv_req(conv_req),
        .conv_strobe(conv_strobe), .conv_data(conv_data), .event_out(event_out),
        .event_oe(event_oe));
    tae_conv_model i_conv (.ref_clk(ref_clk), .conv_req(conv_req), .temp_set(temp_set),
        .conv_strobe(conv_strobe), .conv_data(conv_data));

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp_word(input string what, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_bit(input string what, input logic e, input logic g);
        cmp_word(what, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, ptr: p, wdata: d};
        @(posedge ref_clk);
        reg_req.wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] p, input logic [15:0] e);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, ptr: p, wdata: 16'h0000};
        @(posedge ref_clk);
        reg_req.rd <= 1'b0;
        @(negedge ref_clk);
        cmp_bit("read valid", 1'b1, reg_rd_valid);
        cmp_word("read data", e, reg_rd_data);
    endtask
    // mode and banding only move while the output is disabled
    task automatic set_cfg(input logic [15:0] v);
        wr(8'h01, v & 16'hFFF7);
        wr(8'h01, v);
    endtask
    task automatic convert(input logic [12:0] t);
        int n;
        n = 0;
        temp_set = t;
        @(posedge ref_clk);
        while (conv_req !== 1'b1 && n < 300)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 300)
            fails++;
        repeat (10) @(posedge ref_clk);
    endtask
    task automatic oe_is(input logic e);
        repeat (4) @(negedge ref_clk);
        cmp_bit("event_oe", e, event_oe);
        cmp_bit("event_out", 1'b0, event_out);
    endtask
    task automatic alert();
        @(posedge ref_clk);
        alert_resp_won <= 1'b1;
        @(posedge ref_clk);
        alert_resp_won <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
    endtask

    initial
    begin
        #500000;
        fails++;
        final_report();
    end

    initial
    begin
        do_reset();
        for (int p = 1; p < 6; p++)
            rd_chk(8'(p), 16'h0000);
        convert(13'h0551);
        oe_is(1'b0);
        wr(8'h02, 16'h0550);
        wr(8'h03, 16'h0140);
        wr(8'h04, 16'h05F0);
        repeat (CONV + 20) @(posedge ref_clk);
        cur_cfg = 16'hFFFF;
        for (int i = 0; i < 18; i++)
        begin
            if (rows[i].cfg !== cur_cfg)
                set_cfg(rows[i].cfg);
            cur_cfg = rows[i].cfg;
            convert(rows[i].temp);
            oe_is(rows[i].oe);
            rd_chk(8'h05, {rows[i].flags, rows[i].temp});
        end
        set_cfg(16'h0408);
        convert(13'h0551);
        convert(13'h0530);
        oe_is(1'b1);
        convert(13'h0520);
        oe_is(1'b0);
        convert(13'h0551);
        rd_chk(8'h01, 16'h0418);
        wr(8'h01, 16'h0428);
        oe_is(1'b1);
        wr(8'h02, 16'h0600);
        oe_is(1'b1);
        convert(13'h0551);
        convert(13'h0551);
        oe_is(1'b0);
        wr(8'h02, 16'h0550);
        set_cfg(16'h0009);
        convert(13'h0300);
        convert(13'h0300);
        wr(8'h01, 16'h0029);
        oe_is(1'b0);
        convert(13'h0551);
        oe_is(1'b1);
        wr(8'h01, 16'h0029);
        oe_is(1'b0);
        convert(13'h0300);
        oe_is(1'b1);
        alert();
        oe_is(1'b0);
        convert(13'h05F0);
        oe_is(1'b1);
        wr(8'h01, 16'h0029);
        oe_is(1'b1);
        alert();
        oe_is(1'b1);
        wr(8'h01, 16'h0109);
        wr(8'h01, 16'h010B);
        oe_is(1'b1);
        wr(8'h01, 16'h0009);
        convert(13'h05EF);
        oe_is(1'b0);
        wr(8'h03, 16'hFFFF);
        rd_chk(8'h03, 16'h1FFC);
        wr(8'h01, 16'h00C9);
        wr(8'h02, 16'h0123);
        wr(8'h04, 16'h0100);
        rd_chk(8'h02, 16'h0550);
        rd_chk(8'h04, 16'h05F0);
        rd_chk(8'h07, 16'h0000);
        do_reset();
        oe_is(1'b0);
        for (int p = 1; p < 6; p++)
            rd_chk(8'(p), 16'h0000);
        wr(8'h02, 16'h0123);
        rd_chk(8'h02, 16'h0120);
        final_report();
    end
endmodule
`default_nettype wire
